// File: aipr_pkg.sv
/*
  aipr_pkg: constants shared by the mixer input pair router.
  Assumes a 20 MHz aclk and a 48 kHz audio sample rate.
*/
`default_nettype none

package aipr_pkg;

  // channel and pair counts, sample width and fifo depth
  localparam int NPAIR            = 8;
  localparam int NCHAN            = 16;
  localparam int SAMPLE_W         = 24;
  localparam int SDI_PAIRS        = 8;
  localparam int AES_PAIRS_STD    = 4;
  localparam int AES_PAIRS_EXT    = 6;
  localparam int ANA_PAIRS        = 2;
  localparam int DEC_PAIRS        = 4;
  localparam int DEC_CH_CONSUMER  = 6;
  localparam int DEC_CH_BROADCAST = 8;
  localparam int FIFO_DEPTH       = 4;

  // source kinds and pair modes as held in a pair register
  typedef enum logic [1:0] {SRC_SDI = 2'h0, SRC_AES = 2'h1, SRC_ANA = 2'h2, SRC_DEC = 2'h3} aipr_src_type;
  typedef enum logic [1:0] {MODE_AUDIO = 2'h0, MODE_DATA = 2'h1, MODE_AUTO = 2'h2} aipr_mode_type;

  // pair register fields
  localparam int CFG_SRC_LSB  = 0;
  localparam int CFG_SRC_W    = 2;
  localparam int CFG_SEL_LSB  = 2;
  localparam int CFG_SEL_W    = 3;
  localparam int CFG_MODE_LSB = 5;
  localparam int CFG_MODE_W   = 2;
  localparam int CFG_W        = 7;
  localparam int CFG_PEND_BIT = 7;
  localparam logic [6:0] CFG_RST = 7'h00;

  // register offsets and status fields, pair n sits at OFS_PAIR0 + 4n
  localparam logic [7:0] OFS_PAIR0  = 8'h00;
  localparam logic [7:0] OFS_STATUS = 8'h20;
  localparam logic [7:0] OFS_INFO   = 8'h24;
  localparam int STAT_OVF_LSB   = 0;
  localparam int STAT_OVF_W     = 16;
  localparam int STAT_LVL_LSB   = 16;
  localparam int STAT_BCAST_BIT = 20;

  // bus answers
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // sample boundary timing
  localparam int CLK_HZ     = 20000000;
  localparam int SAMPLE_HZ  = 48000;
  localparam int SAMPLE_DIV = CLK_HZ / SAMPLE_HZ;

endpackage

`default_nettype wire

// File: aipr_router.sv
/*
  aipr_router: selects a source for each of the eight mixer input pairs,
  buffers routed sample frames in a small FIFO, AXI4-Lite register slave.
  Assumes source samples are stable in the cycle after sample_tick and the
  mixer drains mix_valid/mix_ready on the same aclk.
*/
// Added by the designer: the placing of the registers and register access over AXI4-Lite.
`timescale 1ns/10ps
`default_nettype none

////////////////////////////////////////////////////////////////////////
module aipr_fifo import aipr_pkg::*; #(
  parameter int WIDTH = 8,
  parameter int DEPTH = FIFO_DEPTH
) (
  // clock and reset
  input  wire logic             aclk,
  input  wire logic             aresetn,
  // filling side
  input  wire logic [WIDTH-1:0] in_data,
  input  wire logic             in_valid,
  output logic                  in_ready,
  // draining side
  output logic [WIDTH-1:0]      out_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  // fill level
  output logic [$clog2(DEPTH):0] level
);
  localparam int AW = $clog2(DEPTH);
  localparam logic [AW:0] FULL = (AW+1)'(DEPTH);

  logic [WIDTH-1:0] mem_reg [DEPTH];
  logic [AW-1:0]    wr_ptr_reg;
  logic [AW-1:0]    rd_ptr_reg;
  logic [AW:0]      count_reg;
  logic             push;
  logic             pop;

  // depth must be a power of two, pointers wrap by overflow
  assign in_ready  = count_reg != FULL;
  assign out_valid = count_reg != '0;
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;
  assign out_data  = mem_reg[rd_ptr_reg];
  assign level     = count_reg;

  // storage, no reset needed since count guards every read
  always_ff @(posedge aclk) begin
    if (push) begin
      mem_reg[wr_ptr_reg] <= in_data;
    end
  end

  // pointers and fill count
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg  <= '0;
    end else begin
      if (push) begin
        wr_ptr_reg <= wr_ptr_reg + 1'b1;
      end
      if (pop) begin
        rd_ptr_reg <= rd_ptr_reg + 1'b1;
      end
      count_reg <= count_reg + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule

////////////////////////////////////////////////////////////////////////
module aipr_router import aipr_pkg::*; #(
  parameter int DW        = SAMPLE_W,
  parameter int AES_PAIRS = AES_PAIRS_STD
) (
  // clock and reset
  input  wire logic                  aclk,
  input  wire logic                  aresetn,
  // axi4-lite write
  input  wire logic [7:0]            s_axi_awaddr,
  input  wire logic                  s_axi_awvalid,
  output logic                       s_axi_awready,
  input  wire logic [31:0]           s_axi_wdata,
  input  wire logic [3:0]            s_axi_wstrb,
  input  wire logic                  s_axi_wvalid,
  output logic                       s_axi_wready,
  output logic [1:0]                 s_axi_bresp,
  output logic                       s_axi_bvalid,
  input  wire logic                  s_axi_bready,
  // axi4-lite read
  input  wire logic [7:0]            s_axi_araddr,
  input  wire logic                  s_axi_arvalid,
  output logic                       s_axi_arready,
  output logic [31:0]                s_axi_rdata,
  output logic [1:0]                 s_axi_rresp,
  output logic                       s_axi_rvalid,
  input  wire logic                  s_axi_rready,
  // sources, channel n in bits n*DW
  input  wire logic [2*SDI_PAIRS*DW-1:0]     sdi_data,
  input  wire logic [SDI_PAIRS-1:0]          sdi_nonpcm,
  input  wire logic [2*AES_PAIRS_EXT*DW-1:0] aes_data,
  input  wire logic [AES_PAIRS_EXT-1:0]      aes_nonpcm,
  input  wire logic [2*ANA_PAIRS*DW-1:0]     ana_data,
  input  wire logic [2*DEC_PAIRS*DW-1:0]     dec_data,
  input  wire logic                          dec_broadcast,
  // sample boundary and back-pressure
  output logic                       sample_tick,
  output logic                       src_ready,
  // mixer side
  output logic [NCHAN*DW-1:0]        mix_data,
  output logic [NCHAN-1:0]           mix_live,
  output logic [NPAIR-1:0]           mix_bypass,
  output logic                       mix_valid,
  input  wire logic                  mix_ready
);
  localparam int DIVW = $clog2(SAMPLE_DIV);
  localparam logic [DIVW-1:0] DIV_LAST = DIVW'(SAMPLE_DIV - 1);
  localparam int FW = NCHAN*DW + NCHAN + NPAIR;
  localparam int TICK_GAP = SAMPLE_DIV;

  logic [CFG_W-1:0]      shadow_reg [NPAIR];
  logic [CFG_W-1:0]      active_reg [NPAIR];
  logic [NPAIR*CFG_W-1:0] shadow_flat, active_flat;
  logic [DIVW-1:0]       div_cnt_reg;
  logic                  tick_reg, frame_reg;
  logic                  aw_hold_reg, w_hold_reg, strb0_reg;
  logic [7:0]            aw_addr_reg;
  logic [31:0]           w_data_reg;
  logic                  bvalid_reg, rvalid_reg;
  logic [1:0]            bresp_reg, rresp_reg;
  logic [31:0]           rdata_reg, rd_word;
  logic [1:0]            rd_resp;
  logic                  wr_do, wr_cfg, wr_legal;
  logic [STAT_OVF_W-1:0] ovf_reg;
  logic [NCHAN*DW-1:0]   frame_data;
  logic [NCHAN-1:0]      frame_live;
  logic [NPAIR-1:0]      frame_bypass;
  logic                  fifo_ready;
  logic [$clog2(FIFO_DEPTH):0] fifo_level;

  // choice legality per source kind, shared by the slave and the checks
  function automatic logic cfg_legal(input logic [CFG_W-1:0] c);
    int sel;
    logic ok;
    sel = int'(c[CFG_SEL_LSB +: CFG_SEL_W]);
    case (aipr_src_type'(c[CFG_SRC_LSB +: CFG_SRC_W]))
      SRC_SDI: ok = sel < SDI_PAIRS;
      SRC_AES: ok = sel < AES_PAIRS;
      SRC_ANA: ok = sel < ANA_PAIRS;
      SRC_DEC: ok = sel < DEC_PAIRS;
      default: ok = 1'b0;
    endcase
    return ok && (c[CFG_MODE_LSB +: CFG_MODE_W] != 2'h3);
  endfunction

  ////////////////////////////////////////////////////////////////////
  // sample rate divider, one enable pulse per audio sample
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      div_cnt_reg <= '0;
      tick_reg    <= 1'b0;
      frame_reg   <= 1'b0;
    end else begin
      div_cnt_reg <= (div_cnt_reg == DIV_LAST) ? '0 : div_cnt_reg + 1'b1;
      tick_reg    <= div_cnt_reg == DIV_LAST;
      frame_reg   <= tick_reg;
    end
  end
  assign sample_tick = tick_reg;

  ////////////////////////////////////////////////////////////////////
  // write channel: address and data taken in either order, held until both
  assign s_axi_awready = !aw_hold_reg && !bvalid_reg;
  assign s_axi_wready  = !w_hold_reg && !bvalid_reg;
  assign wr_do    = aw_hold_reg && w_hold_reg && !bvalid_reg;
  assign wr_cfg   = aw_addr_reg[7:5] == OFS_PAIR0[7:5];
  assign wr_legal = cfg_legal(w_data_reg[CFG_W-1:0]);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_hold_reg <= 1'b0;
      aw_addr_reg <= 8'h00;
    end else if (wr_do) begin
      aw_hold_reg <= 1'b0;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_hold_reg <= 1'b1;
      aw_addr_reg <= s_axi_awaddr;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_hold_reg <= 1'b0;
      w_data_reg <= 32'h0;
      strb0_reg  <= 1'b0;
    end else if (wr_do) begin
      w_hold_reg <= 1'b0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_hold_reg <= 1'b1;
      w_data_reg <= s_axi_wdata;
      strb0_reg  <= s_axi_wstrb[0];
    end
  end

  // illegal choices are refused so the shadow never holds one
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid_reg <= 1'b0;
      bresp_reg  <= RESP_OKAY;
    end else if (wr_do) begin
      bvalid_reg <= 1'b1;
      bresp_reg  <= (wr_cfg && (!strb0_reg || wr_legal)) ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_bready) begin
      bvalid_reg <= 1'b0;
    end
  end
  assign s_axi_bvalid = bvalid_reg;
  assign s_axi_bresp  = bresp_reg;

  ////////////////////////////////////////////////////////////////////
  // pair settings: software writes the shadow, the tick loads the active copy
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      for (int p = 0; p < NPAIR; p++) begin
        shadow_reg[p] <= CFG_RST | CFG_W'(p << CFG_SEL_LSB);
      end
    end else if (wr_do && wr_cfg && strb0_reg && wr_legal) begin
      shadow_reg[aw_addr_reg[4:2]] <= w_data_reg[CFG_W-1:0];
    end
  end

  // a change never lands mid-sample
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      for (int p = 0; p < NPAIR; p++) begin
        active_reg[p] <= CFG_RST | CFG_W'(p << CFG_SEL_LSB);
      end
    end else if (tick_reg) begin
      active_reg <= shadow_reg;
    end
  end

  always_comb begin
    for (int p = 0; p < NPAIR; p++) begin
      shadow_flat[p*CFG_W +: CFG_W] = shadow_reg[p];
      active_flat[p*CFG_W +: CFG_W] = active_reg[p];
    end
  end

  ////////////////////////////////////////////////////////////////////
  // read channel, one word answered the cycle after the address is taken
  always_comb begin
    rd_word = 32'h0;
    rd_resp = RESP_OKAY;
    if (s_axi_araddr[7:5] == OFS_PAIR0[7:5]) begin
      rd_word[CFG_W-1:0]   = shadow_reg[s_axi_araddr[4:2]];
      rd_word[CFG_PEND_BIT] = shadow_reg[s_axi_araddr[4:2]] != active_reg[s_axi_araddr[4:2]];
    end else if (s_axi_araddr[7:2] == OFS_STATUS[7:2]) begin
      rd_word[STAT_OVF_LSB +: STAT_OVF_W] = ovf_reg;
      rd_word[STAT_LVL_LSB +: $bits(fifo_level)] = fifo_level;
      rd_word[STAT_BCAST_BIT] = dec_broadcast;
    end else if (s_axi_araddr[7:2] == OFS_INFO[7:2]) begin
      rd_word[3:0] = 4'(AES_PAIRS);
    end else begin
      rd_resp = RESP_SLVERR;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_reg <= 1'b0;
      rdata_reg  <= 32'h0;
      rresp_reg  <= RESP_OKAY;
    end else if (s_axi_arvalid && !rvalid_reg) begin
      rvalid_reg <= 1'b1;
      rdata_reg  <= rd_word;
      rresp_reg  <= rd_resp;
    end else if (s_axi_rready) begin
      rvalid_reg <= 1'b0;
    end
  end
  assign s_axi_arready = !rvalid_reg;
  assign s_axi_rvalid  = rvalid_reg;
  assign s_axi_rdata   = rdata_reg;
  assign s_axi_rresp   = rresp_reg;

  ////////////////////////////////////////////////////////////////////
  // frame build: pair p feeds channels 2p and 2p+1
  always_comb begin
    int sel;
    int lim;
    logic np;
    logic [1:0] md;
    sel = 0;
    np  = 1'b0;
    md  = 2'h0;
    lim = dec_broadcast ? DEC_CH_BROADCAST : DEC_CH_CONSUMER;
    frame_data   = '0;
    frame_live   = '0;
    frame_bypass = '0;
    for (int p = 0; p < NPAIR; p++) begin
      sel = int'(active_reg[p][CFG_SEL_LSB +: CFG_SEL_W]);
      md  = active_reg[p][CFG_MODE_LSB +: CFG_MODE_W];
      np  = 1'b0;
      frame_live[2*p +: 2] = 2'b11;
      case (aipr_src_type'(active_reg[p][CFG_SRC_LSB +: CFG_SRC_W]))
        SRC_SDI: begin
          frame_data[2*p*DW +: 2*DW] = sdi_data[sel*2*DW +: 2*DW];
          np = sdi_nonpcm[sel];
        end
        SRC_AES: begin
          frame_data[2*p*DW +: 2*DW] = aes_data[sel*2*DW +: 2*DW];
          np = aes_nonpcm[sel];
        end
        SRC_ANA: begin
          frame_data[2*p*DW +: 2*DW] = ana_data[sel[0]*2*DW +: 2*DW];
        end
        SRC_DEC: begin
          // channels past the format's count are silenced, not passed
          frame_live[2*p]   = 2*sel < lim;
          frame_live[2*p+1] = 2*sel+1 < lim;
          if (frame_live[2*p]) begin
            frame_data[2*p*DW +: DW] = dec_data[2*sel*DW +: DW];
          end
          if (frame_live[2*p+1]) begin
            frame_data[(2*p+1)*DW +: DW] = dec_data[(2*sel+1)*DW +: DW];
          end
        end
        default: frame_live[2*p +: 2] = 2'b00;
      endcase
      // auto follows the source's own non-pcm flag
      frame_bypass[p] = (md == MODE_DATA) || (md == MODE_AUTO && np);
    end
  end

  ////////////////////////////////////////////////////////////////////
  // output buffer; a full fifo at a sample drops it and counts an overflow
  aipr_fifo #(.WIDTH(FW), .DEPTH(FIFO_DEPTH)) u_fifo (
    .aclk      (aclk),
    .aresetn   (aresetn),
    .in_data   ({frame_bypass, frame_live, frame_data}),
    .in_valid  (frame_reg),
    .in_ready  (fifo_ready),
    .out_data  ({mix_bypass, mix_live, mix_data}),
    .out_valid (mix_valid),
    .out_ready (mix_ready),
    .level     (fifo_level)
  );
  assign src_ready = fifo_ready;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ovf_reg <= '0;
    end else if (frame_reg && !fifo_ready && ovf_reg != '1) begin
      ovf_reg <= ovf_reg + 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  logic dec_hi_live, dec_low_dead, data_missing;
  always_comb begin
    dec_hi_live  = 1'b0;
    dec_low_dead = 1'b0;
    data_missing = 1'b0;
    for (int p = 0; p < NPAIR; p++) begin
      if (active_reg[p][1:0] == SRC_DEC) begin
        dec_hi_live  |= (active_reg[p][4:2] == 3'h3) && (frame_live[2*p +: 2] != 2'b00);
        dec_low_dead |= frame_live[2*p +: 2] != 2'b11;
      end
      data_missing |= (active_reg[p][6:5] == MODE_DATA) && !frame_bypass[p];
    end
  end

  AST_ACTIVE_ONLY_AT_TICK: assert property (!tick_reg |=> $stable(active_flat))
    else $error("active routing changed away from a sample boundary");
  AST_TICK_PERIOD: assert property (tick_reg |-> ##[TICK_GAP:TICK_GAP] tick_reg)
    else $error("sample boundary period wrong");
  AST_TICK_LOADS_SHADOW: assert property (tick_reg |=> active_flat == $past(shadow_flat))
    else $error("boundary did not load pending routing");
  AST_ACTIVE_LEGAL: assert property (cfg_legal(active_reg[0]) && cfg_legal(active_reg[7]))
    else $error("illegal pair choice became active");
  AST_ILLEGAL_REFUSED: assert property (wr_do && wr_cfg && strb0_reg && !wr_legal
      |=> s_axi_bvalid && s_axi_bresp == RESP_SLVERR && $stable(shadow_flat))
    else $error("illegal choice not refused");
  AST_CONSUMER_SIX: assert property (frame_reg && !dec_broadcast |-> !dec_hi_live)
    else $error("decoder channel past six passed in consumer format");
  AST_BROADCAST_EIGHT: assert property (frame_reg && dec_broadcast |-> !dec_low_dead)
    else $error("decoder channel dropped in broadcast format");
  AST_DATA_BYPASS: assert property (frame_reg |-> !data_missing)
    else $error("data mode pair not marked bypass");
  AST_SDI_ROUTE: assert property (frame_reg && active_reg[0][1:0] == SRC_SDI
      |-> frame_data[2*DW-1:0] == sdi_data[active_reg[0][4:2]*2*DW +: 2*DW])
    else $error("embedded pair routed wrongly");
  AST_OVF_COUNT: assert property (frame_reg && !fifo_ready && ovf_reg == '0 |=> ovf_reg == 1)
    else $error("overflow not counted");

  COV_PENDING_APPLIED: cover property (shadow_flat != active_flat ##1 tick_reg ##1 shadow_flat == active_flat);
  COV_REFUSED_WRITE: cover property (s_axi_bvalid && s_axi_bresp == RESP_SLVERR);
  COV_FIFO_FULL: cover property (frame_reg && !fifo_ready);
  COV_DEC_HIGH_PAIR: cover property (frame_reg && dec_broadcast && active_reg[0] == 7'h0F);
endmodule

`default_nettype wire

// File: aipr_mixer_model.sv
/*
  aipr_mixer_model: behavioural mixer input stage that drains routed frames
  and keeps the last one taken for the bench to inspect.
  Assumes the router's aclk and aresetn; stall is driven by the bench.
*/
`timescale 1ns/10ps
`default_nettype none

module aipr_mixer_model import aipr_pkg::*; #(
  parameter int DW = SAMPLE_W
) (
  // clock and reset
  input  wire logic              aclk,
  input  wire logic              aresetn,
  // bench control, high holds the mixer off
  input  wire logic              stall,
  // frame stream from the router
  input  wire logic [NCHAN*DW-1:0] mix_data,
  input  wire logic [NCHAN-1:0]  mix_live,
  input  wire logic [NPAIR-1:0]  mix_bypass,
  input  wire logic              mix_valid,
  output logic                   mix_ready,
  // last frame taken
  output logic [NCHAN*DW-1:0]    got_data,
  output logic [NCHAN-1:0]       got_live,
  output logic [NPAIR-1:0]       got_bypass,
  output logic [15:0]            got_count
);

  ////////////////////////////////////////////////////////////////////////
  // ready drops while stalled so the router's buffer can fill up
  assign mix_ready = aresetn && !stall;

  // samples are kept untouched, so bypass payloads stay bit exact
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      got_count <= 16'h0000;
    end else if (mix_valid && mix_ready) begin
      got_data   <= mix_data;
      got_live   <= mix_live;
      got_bypass <= mix_bypass;
      got_count  <= got_count + 16'h0001;
    end
  end

endmodule

`default_nettype wire

// File: test_aipr_router.sv
/*
  test_aipr_router: self-checking bench for the mixer input pair router.
  Assumes aipr_pkg and aipr_mixer_model are compiled first.
*/
`timescale 1ns/10ps
`default_nettype none

module test_aipr_router import aipr_pkg::*;;
  localparam int DW = SAMPLE_W;
  // bus and sources, all driven by the bench
  logic                 aclk = 0, aresetn = 0, stall = 0, bcast = 0;
  logic [7:0]           awaddr = 0, araddr = 0;
  logic                 awv = 0, wv = 0, bready = 0, arv = 0, rready = 0;
  logic [31:0]          wdata = 0;
  logic [3:0]           wstrb = 4'hF;
  logic [2*SDI_PAIRS*DW-1:0] sdi = 0;
  logic [2*AES_PAIRS_EXT*DW-1:0] aes = 0;
  logic [2*ANA_PAIRS*DW-1:0] ana = 0;
  logic [2*DEC_PAIRS*DW-1:0] dec = 0;
  logic [7:0]           sdi_np = 8'h20;
  logic [5:0]           aes_np = 6'h08;
  // design answers
  logic                 awrdy, wrdy, bvld, arrdy, rvld, tick, srdy, mvalid, mready;
  logic [1:0]           bresp, rresp;
  logic [31:0]          rdata;
  logic [NCHAN*DW-1:0]  mdata, gdata;
  logic [NCHAN-1:0]     mlive, glive;
  logic [NPAIR-1:0]     mbyp, gbyp;
  logic [15:0]          gcnt;
  int                   n_fail = 0, checks_done = 0;
  // pair settings in force, starting from the reset routing
  int                   cs[8] = '{0, 0, 0, 0, 0, 0, 0, 0};
  int                   ck[8] = '{0, 1, 2, 3, 4, 5, 6, 7};
  int                   cm[8] = '{0, 0, 0, 0, 0, 0, 0, 0};

  always #25 aclk = ~aclk;

  aipr_router i_dut (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awv), .s_axi_awready(awrdy), .s_axi_wdata(wdata),
    .s_axi_wstrb(wstrb), .s_axi_wvalid(wv), .s_axi_wready(wrdy), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvld), .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arv),
    .s_axi_arready(arrdy), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvld),
    .s_axi_rready(rready), .sdi_data(sdi), .sdi_nonpcm(sdi_np), .aes_data(aes),
    .aes_nonpcm(aes_np), .ana_data(ana), .dec_data(dec), .dec_broadcast(bcast),
    .sample_tick(tick), .src_ready(srdy), .mix_data(mdata), .mix_live(mlive),
    .mix_bypass(mbyp), .mix_valid(mvalid), .mix_ready(mready));

  aipr_mixer_model i_mix (.aclk(aclk), .aresetn(aresetn), .stall(stall), .mix_data(mdata),
    .mix_live(mlive), .mix_bypass(mbyp), .mix_valid(mvalid), .mix_ready(mready),
    .got_data(gdata), .got_live(glive), .got_bypass(gbyp), .got_count(gcnt));

  ////////////////////////////////////////////////////////////////////////
  // unique sample per source kind and channel, so a wrong route shows
  function automatic logic [DW-1:0] val(input int s, input int ch);
    return DW'((s + 1) * 32'h100000 + ch);
  endfunction

  task automatic chk(input string what, input logic [31:0] e, input logic [31:0] g);
    checks_done++;
    if (g !== e) begin
      n_fail++;
      $display("unexpected %s expected %h seen %h", what, e, g);
    end
  endtask

  task automatic results;
    $display("checks %0d mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  // each channel is released at the edge where its ready is seen high;
  // bready and rready stay up so back to back calls never assign them twice
  task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    logic seen;
    int n;
    n = 0;
    seen = 0;
    awaddr <= a;
    wdata  <= d;
    awv    <= 1;
    wv     <= 1;
    bready <= 1;
    while (!seen && n < 200) begin
      @(posedge aclk);
      n++;
      if (awv && awrdy) awv <= 0;
      if (wv && wrdy) wv <= 0;
      seen = bvld;
      r = bresp;
    end
    if (!seen) chk("write answer time", 0, 1);
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    logic seen;
    int n;
    n = 0;
    seen = 0;
    araddr <= a;
    arv    <= 1;
    rready <= 1;
    while (!seen && n < 200) begin
      @(posedge aclk);
      n++;
      if (arv && arrdy) arv <= 0;
      seen = rvld;
      d = rdata;
      r = rresp;
    end
    if (!seen) chk("read answer time", 0, 1);
  endtask

  task automatic wait_ticks(input int k);
    int n;
    repeat (k) begin
      n = 0;
      do begin @(negedge aclk); n++; end while (!tick && n < 500);
      if (!tick) chk("sample tick wait", 0, 1);
    end
    @(posedge aclk);
  endtask

  task automatic next_frame;
    logic [15:0] c;
    int n;
    c = gcnt; n = 0;
    do begin @(negedge aclk); n++; end while (gcnt == c && n < 1000);
    if (gcnt == c) chk("frame wait", 0, 1);
    @(posedge aclk);
  endtask

  task automatic check_frame(input logic bc);
    int s, ch;
    logic lv, eb;
    for (int p = 0; p < NPAIR; p++) begin
      s = cs[p];
      for (int j = 0; j < 2; j++) begin
        ch = 2 * ck[p] + j;
        lv = !(s == 3 && !bc && ch >= DEC_CH_CONSUMER);
        chk("mix channel", 32'(lv ? val(s, ch) : '0), 32'(gdata[(2*p+j)*DW +: DW])); // feed
        chk("mix live", 32'(lv), 32'(glive[2*p+j])); // live channels
      end
      eb = cm[p] == 1 || (cm[p] == 2 && ((s == 0 && sdi_np[ck[p]]) || (s == 1 && aes_np[ck[p]])));
      chk("mix bypass", 32'(eb), 32'(gbyp[p])); // pair mode
    end
  endtask

  ////////////////////////////////////////////////////////////////////////
  // reset values, info word, unmapped read and the reset routing
  task automatic t_reset;
    logic [31:0] d;
    logic [1:0] r;
    for (int p = 0; p < NPAIR; p++) begin
      rd(8'(4 * p), d, r);
      chk("pair reset", 32'(p << 2), d); // reset setting
    end
    rd(OFS_INFO, d, r);
    chk("info", 32'(AES_PAIRS_STD), d); // aes choice count
    rd(8'h40, d, r);
    chk("unmapped read", {30'h0, RESP_SLVERR}, {d[29:0], r});
    next_frame;
    check_frame(0); // reset routing
  endtask

  // every source kind against every pair select, plus refused writes
  task automatic t_legal;
    int lim[4] = '{SDI_PAIRS, AES_PAIRS_STD, ANA_PAIRS, DEC_PAIRS};
    logic [31:0] d, last;
    logic [1:0] r;
    last = 32'h1C;
    for (int s = 0; s < 4; s++) begin
      for (int k = 0; k < 8; k++) begin
        wr(8'h1C, 32'((k << 2) | s), r);
        chk("select answer", 32'(k < lim[s] ? RESP_OKAY : RESP_SLVERR), 32'(r));
        if (k < lim[s]) last = 32'((k << 2) | s);
      end
    end
    wr(8'h1C, 32'h60, r);
    chk("mode 3 answer", 32'(RESP_SLVERR), 32'(r)); // three modes only
    wr(OFS_STATUS, 32'h0, r);
    chk("status write", 32'(RESP_SLVERR), 32'(r));
    wstrb <= 4'hE;
    wr(8'h1C, 32'h1, r);
    chk("masked write answer", 32'(RESP_OKAY), 32'(r)); // low lane off keeps pair
    wstrb <= 4'hF;
    rd(8'h1C, d, r);
    chk("pair readback", last, d & 32'h7F); // choice kept by kind
  endtask

  // mixed routing table, change held until the next sample boundary
  task automatic t_route;
    logic [31:0] d;
    logic [1:0] r;
    cs = '{0, 1, 2, 3, 0, 0, 3, 1};
    ck = '{7, 3, 1, 3, 2, 5, 0, 0};
    cm = '{0, 2, 2, 0, 1, 2, 1, 2};
    wait_ticks(1);
    for (int p = 0; p < NPAIR; p++) wr(8'(4 * p), 32'((cm[p] << 5) | (ck[p] << 2) | cs[p]), r);
    rd(OFS_PAIR0, d, r);
    chk("pending before tick", 32'h1, 32'(d[CFG_PEND_BIT])); // boundary only
    wait_ticks(1);
    next_frame;
    check_frame(0); // consumer decoder
    rd(OFS_PAIR0, d, r);
    chk("pending after tick", 32'h0, 32'(d[CFG_PEND_BIT])); // boundary reached
    bcast <= 1;
    wait_ticks(1);
    next_frame;
    check_frame(1); // broadcast decoder
  endtask

  // stalled mixer: buffer fills to four, two frames dropped, then drains
  task automatic t_overflow;
    logic [31:0] d;
    logic [1:0] r;
    next_frame;
    stall <= 1;
    wait_ticks(6);
    repeat (3) @(posedge aclk);
    rd(OFS_STATUS, d, r);
    chk("overflow count", 32'h2, 32'(d[15:0]));
    chk("fifo level", 32'h4, 32'(d[18:16]));
    chk("status decoder kind", 32'(bcast), 32'(d[STAT_BCAST_BIT]));
    @(negedge aclk);
    chk("room while full", 32'h0, 32'(srdy));
    @(posedge aclk);
    stall <= 0;
    repeat (4) next_frame;
    check_frame(1); // drained frames keep routing
  endtask

  ////////////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    for (int c = 0; c < 16; c++) sdi[c*DW +: DW] = val(0, c);
    for (int c = 0; c < 12; c++) aes[c*DW +: DW] = val(1, c);
    for (int c = 0; c < 4; c++) ana[c*DW +: DW] = val(2, c);
    for (int c = 0; c < 8; c++) dec[c*DW +: DW] = val(3, c);
    repeat (12) @(posedge aclk);
    aresetn <= 1;
    t_reset;
    t_legal;
    t_route;
    t_overflow;
    results;
  end

  // watchdog, the tests need well under ten thousand cycles
  initial begin
    repeat (40000) @(posedge aclk);
    n_fail++;
    $display("unexpected watchdog expected done seen hang");
    results;
  end

endmodule

`default_nettype wire
